// [bench/ext_clock_source.sv]
// Model of the external count clock source that drives the counter pin.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic [7:0] half_i,
	output logic pin_o
);
	logic [7:0] cnt_r;
	// Toggles every half_i clocks while run_i is high and stands still otherwise.
	// It starts high after reset and holds its level between bursts; a larger half_i gives a slow source.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= 8'h00;
			pin_o <= 1'b1;
		end else if (!run_i) begin
			cnt_r <= 8'h00;
		end else if (cnt_r == half_i - 8'h01) begin
			cnt_r <= 8'h00;
			pin_o <= ~pin_o;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule // ext_clock_source
`default_nettype wire

// [bench/tb_timer16_prescale_control.sv]
// Self-checking bench for the 16-bit timer with prescaler and gate control.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.vh"
module tb_timer16_prescale_control;
	localparam DIV = 2; // A short instruction cycle keeps the run brief.
	logic clk_i, sys_rst_i, rd, wr, osc, gate_n, run, lp, irq, wreq;
	logic [7:0] adr, half;
	logic [31:0] wd, rdat, q;
	logic [3:0] be;
	wire pin;
	int fails, checked;
	timer16_prescale_control #(.INSTR_DIV(DIV)) timer16_prescale_control_inst (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .ext_count_clock_pin_i(pin), .gate_pin_n_i(gate_n),
		.internal_oscillator_active_i(osc), .lp_osc_on_o(lp), .irq_o(irq));
	ext_clock_source ext_clock_source_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .run_i(run),
		.half_i(half), .pin_o(pin));
	// Clock at 50 MHz.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// One bus access; the request holds until waitrequest is sampled low at a rising edge.
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		adr <= a;
		wd <= {24'h000000, d};
		wr <= w;
		rd <= !w;
		@(posedge clk_i);
		while (wreq !== 1'b0) @(posedge clk_i);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task load(input logic [15:0] v);
		bus(1'b1, `ADDR_COUNT_LOW, v[7:0]);
		bus(1'b1, `ADDR_COUNT_HIGH, v[15:8]);
	endtask
	task t_reset;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'(i * 4), 8'h00);
			chk("reset value", q, 32'h0);
		end
		chk("irq after reset", irq, 32'h0);
	endtask
	task t_ctl;
		bus(1'b1, `ADDR_CONTROL, 8'hff);
		bus(1'b0, `ADDR_CONTROL, 8'h00);
		chk("control", q, 32'h7f);
		chk("osc ignored", lp, 32'h0);
		osc <= 1'b1;
		@(negedge clk_i);
		chk("osc on", lp, 32'h1);
		be <= 4'h0;
		bus(1'b1, `ADDR_CONTROL, 8'h00);
		be <= 4'hf;
		bus(1'b0, `ADDR_CONTROL, 8'h00);
		chk("lane off write", q, 32'h7f);
		bus(1'b1, `ADDR_CONTROL, 8'h00);
		@(negedge clk_i);
		chk("osc off", lp, 32'h0);
		bus(1'b0, 8'h14, 8'h00);
		chk("unmapped", q, 32'h0);
		osc <= 1'b0;
	endtask
	task t_prescale;
		int e;
		for (int ps = 0; ps < 4; ps++) begin
			load(16'h0000);
			bus(1'b1, `ADDR_CONTROL, 8'h01 | 8'(ps * 16));
			repeat (256) @(posedge clk_i);
			bus(1'b1, `ADDR_CONTROL, 8'h00);
			bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
			e = 129 >> ps;
			chk("prescaled count", 32'(q + 1 >= e && q <= e + 1), 32'h1);
		end
	endtask
	// Rewrites come faster than eight events, so only a cleared prescaler keeps zero.
	task t_clear;
		bus(1'b1, `ADDR_CONTROL, 8'h31);
		for (int i = 0; i < 20; i++) begin
			bus(1'b1, `ADDR_COUNT_LOW, 8'h00);
			repeat (4) @(posedge clk_i);
			bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
			chk("cleared prescaler", q, 32'h0);
		end
		bus(1'b1, `ADDR_CONTROL, 8'h00);
	endtask
	task t_roll;
		load(16'hffff);
		bus(1'b1, `ADDR_IRQ_MASK, 8'h01);
		bus(1'b1, `ADDR_CONTROL, 8'h01);
		repeat (20) @(posedge clk_i);
		bus(1'b1, `ADDR_CONTROL, 8'h00);
		bus(1'b0, `ADDR_COUNT_HIGH, 8'h00);
		chk("wrapped high", q, 32'h0);
		bus(1'b0, `ADDR_IRQ_STATUS, 8'h00);
		chk("rollover flag", q, 32'h1);
		chk("irq", irq, 32'h1);
		bus(1'b1, `ADDR_IRQ_MASK, 8'h00);
		@(negedge clk_i);
		chk("irq masked", irq, 32'h0);
		bus(1'b1, `ADDR_IRQ_MASK, 8'h01);
		bus(1'b1, `ADDR_IRQ_STATUS, 8'h01);
		@(negedge clk_i);
		chk("irq cleared", irq, 32'h0);
	endtask
	task t_gate;
		load(16'h0000);
		bus(1'b1, `ADDR_CONTROL, 8'h41);
		repeat (100) @(posedge clk_i);
		bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
		chk("gated off", q, 32'h0);
		gate_n <= 1'b0;
		repeat (100) @(posedge clk_i);
		bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
		chk("gated on", 32'(q != 0), 32'h1);
		bus(1'b1, `ADDR_CONTROL, 8'h00);
		gate_n <= 1'b1;
	endtask
	// Five pulses from the partner: synchronised, passed straight through, then from a low pin.
	task t_ext;
		for (int s = 0; s < 3; s++) begin
			if (s == 2) begin
				run <= 1'b1;
				repeat (4) @(posedge clk_i);
				run <= 1'b0;
			end
			load(16'h0000);
			bus(1'b1, `ADDR_CONTROL, 8'h03 | 8'((s % 2) * 4));
			half <= 8'h04;
			run <= 1'b1;
			repeat (40) @(posedge clk_i);
			run <= 1'b0;
			repeat (20) @(posedge clk_i);
			bus(1'b1, `ADDR_CONTROL, 8'h00);
			bus(1'b0, `ADDR_COUNT_LOW, 8'h00);
			chk("pin edges", q, (s == 2) ? 32'h4 : 32'h5);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// A hang is cut short well past the few thousand cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		summarize;
	end
	initial begin
		{sys_rst_i, rd, wr, osc, gate_n, run} = 6'h22;
		{adr, half, wd, be} = {16'h0004, 32'h0, 4'hf};
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset;
		t_ctl;
		t_prescale;
		t_clear;
		t_roll;
		t_gate;
		t_ext;
		summarize;
	end
endmodule // tb_timer16_prescale_control
`default_nettype wire

// [bench/timer16_checker.sv]
// Assertion checker for the timer register slave and its outputs.
`timescale 1ns/1ps
`default_nettype none
module timer16_checker (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic internal_oscillator_active_i,
	input wire logic lp_osc_on_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Accepted accesses; a write without byte lane 0 changes nothing.
	wire rd_ok = avs_read_i && !avs_waitrequest_o;
	wire wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	a_wait_read: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read not answered after one wait cycle");
	a_wait_write: assert property ($rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("write not answered after one wait cycle");
	a_idle_ready: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
		else $error("wait raised with no request");
	a_read_upper: assert property (rd_ok |-> avs_readdata_o[31:8] == 24'h000000
		&& (avs_address_i != 8'h10 || !avs_readdata_o[7]))
		else $error("unused read bits not zero");
	a_read_unmapped: assert property (rd_ok && avs_address_i > 8'h10 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_osc_gated: assert property (lp_osc_on_o |-> internal_oscillator_active_i)
		else $error("oscillator on without internal oscillator");
	a_osc_follow: assert property (wr_ok && avs_address_i == 8'h10 |=>
		lp_osc_on_o == ($past(avs_writedata_i[3]) && internal_oscillator_active_i))
		else $error("oscillator enable not applied");
	a_mask_off: assert property (wr_ok && avs_address_i == 8'h0c && !avs_writedata_i[0] |=> !irq_o)
		else $error("masked interrupt still high");
	cover property ($rose(irq_o));
	cover property ($rose(lp_osc_on_o));
	cover property (wr_ok && avs_address_i == 8'h10);
endmodule // timer16_checker
bind timer16_prescale_control timer16_checker timer16_checker_inst (.clk_i, .sys_rst_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
	.avs_readdata_o, .avs_waitrequest_o, .internal_oscillator_active_i, .lp_osc_on_o, .irq_o);
`default_nettype wire

// [rtl/timer16_consts.vh]
// Constants for the 16-bit timer with prescaler and gate control.
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// Register byte addresses on the Avalon-MM slave, one 32-bit word each.
`define ADDR_COUNT_LOW 8'h00
`define ADDR_COUNT_HIGH 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0c
`define ADDR_CONTROL 8'h10

// Field positions inside timer_control.
`define CTL_RUN_EN 0
`define CTL_CLK_SEL 1
`define CTL_SYNC_DIS 2
`define CTL_OSC_EN 3
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_GATE_EN 6
`define CTL_WIDTH 7
`define CTL_RESET 7'h00

// Field position of the rollover flag in status and mask.
`define IRQ_ROLL 0
`define IRQ_RESET 1'h0

// Counter and prescaler figures.
`define COUNT_MAX 16'hffff
`define COUNT_RESET 16'h0000
`define PRESCALE_WIDTH 3
`define PRESCALE_RESET 3'h0

// System clocks per instruction cycle.
`define INSTR_CYCLE_CLOCKS 4
`define INSTR_DIV_WIDTH 8

// Prescale select codes.
`define PS_DIV1 2'h0
`define PS_DIV2 2'h1
`define PS_DIV4 2'h2
`define PS_DIV8 2'h3

`endif

// [rtl/timer16_prescale_control.v]
// Top of the 16-bit timer/counter: register slave, clock selection, gating and rollover.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.vh"

module timer16_prescale_control #(
	parameter INSTR_DIV = `INSTR_CYCLE_CLOCKS
) (
	input wire clk_i,
	input wire sys_rst_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire ext_count_clock_pin_i,
	input wire gate_pin_n_i,
	input wire internal_oscillator_active_i,
	output wire lp_osc_on_o,
	output wire irq_o
);

	// Control register and its fields.
	reg [`CTL_WIDTH-1:0] timer_control_r;
	wire run_enable;
	wire clock_source_select;
	wire ext_sync_disable;
	wire lp_osc_enable;
	wire [1:0] prescale_select;
	wire gate_enable;

	// Bus slave state.
	reg ack_r;
	reg [31:0] readdata_r;
	reg [31:0] read_mux;
	wire bus_req;
	wire wr_stb;
	wire wr_low;
	wire wr_high;
	wire wr_status;
	wire wr_mask;
	wire wr_control;

	// Timer state.
	reg [15:0] count_r;
	reg [15:0] count_nxt;
	reg rollover_flag_r;
	reg irq_mask_r;
	reg [`INSTR_DIV_WIDTH-1:0] instr_cnt_r;
	wire instr_tick;

	// Pin synchronisers and filtered levels.
	reg ext_s1_r;
	reg ext_s2_r;
	reg ext_s3_r;
	reg ext_lvl_r;
	reg gate_s1_r;
	reg gate_s2_r;
	reg gate_s3_r;
	reg gate_lvl_r;
	wire ext_agree;
	wire ext_rise;
	wire ext_fall;

	// Counter mode edge handling.
	reg armed_r;
	reg ext_pend_r;
	wire counter_active;
	wire counted_rise;
	wire src_event;
	wire count_enable;
	wire presc_pulse;
	wire prescale_clear;
	wire rollover;
	wire flag_clear;

	// Field decode of the control register.
	assign run_enable = timer_control_r[`CTL_RUN_EN];
	assign clock_source_select = timer_control_r[`CTL_CLK_SEL];
	assign ext_sync_disable = timer_control_r[`CTL_SYNC_DIS];
	assign lp_osc_enable = timer_control_r[`CTL_OSC_EN];
	assign prescale_select = timer_control_r[`CTL_PS_HI:`CTL_PS_LO];
	assign gate_enable = timer_control_r[`CTL_GATE_EN];

	// Every access takes two cycles: waitrequest is high in the first and low in the second.
	// The fixed latency keeps the slave simple at the cost of one bus cycle per access.
	assign bus_req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = bus_req & ~ack_r;
	assign avs_readdata_o = readdata_r;

	// Writes take effect only at the edge where waitrequest is sampled low.
	// Registers hold eight bits or fewer, so only the low byte lane matters.
	assign wr_stb = avs_write_i & ack_r & avs_byteenable_i[0];
	// Exact match of a register address; a partial decode would alias the map.
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	assign wr_low = wr_stb & addr_hit(avs_address_i, `ADDR_COUNT_LOW);
	assign wr_high = wr_stb & addr_hit(avs_address_i, `ADDR_COUNT_HIGH);
	assign wr_status = wr_stb & addr_hit(avs_address_i, `ADDR_IRQ_STATUS);
	assign wr_mask = wr_stb & addr_hit(avs_address_i, `ADDR_IRQ_MASK);
	assign wr_control = wr_stb & addr_hit(avs_address_i, `ADDR_CONTROL);

	// Read multiplexer; unmapped addresses and unused bits read as zero.
	always @* begin
		read_mux = 32'h00000000;
		case (avs_address_i)
			`ADDR_COUNT_LOW: read_mux[7:0] = count_r[7:0];
			`ADDR_COUNT_HIGH: read_mux[7:0] = count_r[15:8];
			`ADDR_IRQ_STATUS: read_mux[`IRQ_ROLL] = rollover_flag_r;
			`ADDR_IRQ_MASK: read_mux[`IRQ_ROLL] = irq_mask_r;
			`ADDR_CONTROL: read_mux[`CTL_WIDTH-1:0] = timer_control_r;
			default: read_mux = 32'h00000000;
		endcase
	end

	// Acknowledge and read data capture; read data stands while waitrequest is low.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_r <= 1'b0;
			readdata_r <= 32'h00000000;
		end else begin
			ack_r <= bus_req & ~ack_r;
			if (avs_read_i & ~ack_r) begin
				readdata_r <= read_mux;
			end
		end
	end

	// Control and mask registers; all control bits start cleared.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			timer_control_r <= `CTL_RESET;
			irq_mask_r <= `IRQ_RESET;
		end else begin
			if (wr_control) begin
				timer_control_r <= avs_writedata_i[`CTL_WIDTH-1:0];
			end
			if (wr_mask) begin
				irq_mask_r <= avs_writedata_i[`IRQ_ROLL];
			end
		end
	end

	// Instruction cycle enable, one pulse every INSTR_DIV system clocks.
	// The counter restarts on the tick itself, so the enable is exactly one cycle wide.
	assign instr_tick = (instr_cnt_r == INSTR_DIV[`INSTR_DIV_WIDTH-1:0] - 8'h01);

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			instr_cnt_r <= 8'h00;
		end else if (instr_tick) begin
			instr_cnt_r <= 8'h00;
		end else begin
			instr_cnt_r <= instr_cnt_r + 8'h01;
		end
	end

	// Three-stage synchronisers for both pins; a level is accepted once stages two and
	// three agree, which also rejects a single-cycle glitch.
	// The gate stages start at the inactive high level so reset never opens the gate.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			ext_lvl_r <= 1'b0;
			gate_s1_r <= 1'b1;
			gate_s2_r <= 1'b1;
			gate_s3_r <= 1'b1;
			gate_lvl_r <= 1'b1;
		end else begin
			ext_s1_r <= ext_count_clock_pin_i;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			if (ext_agree) begin
				ext_lvl_r <= ext_s3_r;
			end
			gate_s1_r <= gate_pin_n_i;
			gate_s2_r <= gate_s1_r;
			gate_s3_r <= gate_s2_r;
			if (gate_s2_r == gate_s3_r) begin
				gate_lvl_r <= gate_s3_r;
			end
		end
	end

	assign ext_agree = (ext_s2_r == ext_s3_r);
	assign ext_rise = ext_agree & ext_s3_r & ~ext_lvl_r;
	assign ext_fall = ext_agree & ~ext_s3_r & ext_lvl_r;

	// A rising edge is only honoured once a falling edge has been seen while counting.
	// A pin already low at enable must fall before a rise counts, so its first rise is lost.
	// Leaving counter mode or stopping disarms, so every enable starts from scratch.
	assign counter_active = run_enable & clock_source_select;
	assign counted_rise = ext_rise & armed_r;

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			armed_r <= 1'b0;
		end else begin
			armed_r <= counter_active & (armed_r | ext_fall);
		end
	end

	// Synchronised counter mode holds a seen edge until the next instruction cycle.
	// A new edge in the same cycle as delivery is kept, not lost.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_pend_r <= 1'b0;
		end else if (~counter_active | ext_sync_disable) begin
			ext_pend_r <= 1'b0;
		end else begin
			ext_pend_r <= counted_rise | (ext_pend_r & ~instr_tick);
		end
	end

	// Source event: instruction cycle, aligned external edge, or raw external edge.
	// The direct path still passes the pin filter; there is no second clock domain here.
	assign src_event = ~clock_source_select ? instr_tick :
		(ext_sync_disable ? counted_rise : (ext_pend_r & instr_tick));

	// Run enable, and the active-low gate pin when gating is on.
	assign count_enable = run_enable & (~gate_enable | ~gate_lvl_r);

	// Any write to either count byte restarts the prescaler.
	// Clearing on either byte keeps a two-byte reload from inheriting a partial ratio.
	assign prescale_clear = wr_low | wr_high;

	timer16_prescaler #(
		.W(`PRESCALE_WIDTH)
	) timer16_prescaler_inst (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(prescale_clear),
		.tick_i(src_event & count_enable),
		.select_i(prescale_select),
		.pulse_o(presc_pulse)
	);

	// A byte write wins over an increment in the same cycle.
	assign rollover = presc_pulse & ~prescale_clear & (count_r == `COUNT_MAX);

	// Next count: a byte write replaces its half, otherwise a prescaler pulse increments it.
	always @* begin
		count_nxt = count_r;
		if (wr_low) begin
			count_nxt[7:0] = avs_writedata_i[7:0];
		end else if (wr_high) begin
			count_nxt[15:8] = avs_writedata_i[7:0];
		end else if (presc_pulse) begin
			count_nxt = count_r + 16'h0001;
		end
	end

	// The count register itself; reset clears both bytes.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_r <= `COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// Write-one-to-clear on the status word; writing a zero leaves the flag alone.
	assign flag_clear = wr_status & avs_writedata_i[`IRQ_ROLL];

	// Sticky rollover flag, cleared by writing one; a rollover in the clearing cycle wins.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rollover_flag_r <= `IRQ_RESET;
		end else begin
			rollover_flag_r <= rollover | (rollover_flag_r & ~flag_clear);
		end
	end

	// Level interrupt; masking only hides the flag, software still has to clear it.
	assign irq_o = rollover_flag_r & irq_mask_r;

	// Oscillator request only counts while the internal oscillator clocks the system.
	assign lp_osc_on_o = lp_osc_enable & internal_oscillator_active_i;

endmodule // timer16_prescale_control

`default_nettype wire

// [rtl/timer16_prescaler.v]
// Prescale divider that turns source events into count pulses at 1:1, 1:2, 1:4 or 1:8.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.vh"

module timer16_prescaler #(
	parameter W = `PRESCALE_WIDTH
) (
	input wire clk_i,
	input wire sys_rst_i,
	input wire clear_i,
	input wire tick_i,
	input wire [1:0] select_i,
	output wire pulse_o
);

	reg [W-1:0] cnt_r;
	reg [W-1:0] cnt_nxt;
	wire [W-1:0] mask;

	// Low bits of the divider that must all be one before a pulse is let through.
	function [W-1:0] mask_of;
		input [1:0] sel;
		begin
			case (sel)
				`PS_DIV1: mask_of = {W{1'b0}};
				`PS_DIV2: mask_of = {{(W-1){1'b0}}, 1'b1};
				`PS_DIV4: mask_of = {{(W-2){1'b0}}, 2'b11};
				default: mask_of = {W{1'b1}};
			endcase
		end
	endfunction

	assign mask = mask_of(select_i);
	// A pulse leaves on the event that completes the selected ratio.
	assign pulse_o = tick_i & ((cnt_r & mask) == mask);

	// Clear has priority so a byte write always restarts the ratio from zero.
	always @* begin
		cnt_nxt = cnt_r;
		if (clear_i) begin
			cnt_nxt = `PRESCALE_RESET;
		end else if (pulse_o) begin
			cnt_nxt = `PRESCALE_RESET;
		end else if (tick_i) begin
			cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// The divider state is not visible to software.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= `PRESCALE_RESET;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule // timer16_prescaler

`default_nettype wire
